// ===== bte_axi_mem.sv
// Memory slave on the master port: single-beat reads, stalling writes.
// Assumes awaddr[7:4] picks one of sixteen 128-bit words.
`timescale 1ns/10ps
// ================================
// Far side model
module bte_axi_mem (
  input wire mclk,
  input wire srst,
  input wire [3:0] awid,
  input wire [31:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [127:0] wdata,
  input wire wlast,
  input wire wvalid,
  output reg wready,
  output reg [3:0] bid,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [3:0] arid,
  input wire [31:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [3:0] rid,
  output reg [127:0] rdata,
  output reg rlast,
  output reg rvalid,
  input wire rready
);
  reg [127:0] mem [0:15];
  reg [3:0] wId;
  reg [3:0] wAt;
  reg wOpen;
  initial begin
    {awready, wready, bvalid, arready, rvalid, rlast, bid, bresp, rid} = 16'h0;
    rdata = 128'h0;
  end
  // One write burst open at a time; reads wait so they never race writes
  always @(posedge mclk) begin
    if (srst) begin
      {awready, wready, bvalid, arready, rvalid, wOpen} <= 6'h0;
    end else begin
      awready <= !wOpen && !(awvalid && awready) && $urandom % 2;
      wready <= wOpen && !(wvalid && wready && wlast) && $urandom % 2;
      arready <= !wOpen && !awvalid && !bvalid && !rvalid && !(arvalid && arready);
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (awvalid && awready) begin
        wOpen <= 1'b1;
        wId <= awid;
        wAt <= awaddr[7:4];
      end
      if (wvalid && wready) begin
        mem[wAt] <= wdata;
        wAt <= wAt + 4'h1;
        wOpen <= !wlast;
        bvalid <= wlast;
        bid <= wId;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rlast <= 1'b1;
        rid <= arid;
        rdata <= mem[araddr[7:4]];
      end
      // Released data lines show the inverse, never the last value
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        rdata <= ~rdata;
      end
    end
  end
endmodule

// ===== bte_engine.v
// Bus traffic engine: APB register and RAM access, command sequencer,
// burst master with per-ID tracking and a 64-bit wide data RAM.
// Assumes the master port faces an AXI4 interconnect on the same clock.
//
// Overview of operation
// - Index generator yields a RAM index per beat and flags burst end.
// - Data RAM is 64 bits by 1024; narrow buses use words unchanged.
// - Wide write beats carry the RAM word repeated across the bus.
// - Wide read beats keep only their low 64 bits in the RAM.
// - Slave requests and answers are buffered before and after the RAMs.
// - Slave writes go to the generated address; answers may reorder.
// - Slave reads are spread over index generators sharing the RAM.
// - Slave port decodes registers, parameter, command, upper and data RAMs.
// - Slave write data of different bursts is never interleaved.
// - Read commands pass a two-entry queue; each ID keeps one tracker slot.
// - With four read IDs outstanding, read commands with a fifth ID wait.
// - Returned beats are queued, matched by ID, written; last beat pops.
// - Write commands fill address and index queues; RAM data feeds a queue.
// - Four write ID slots, each popped by its own write response.
// - Reduced mode issues only full-width bursts and ignores parameters.
// - Reduced mode fixes lock, burst, protection, QoS, cache and size.
// - Static mode repeats fixed INCR writes and reads, optionally sweeping.
`timescale 1ns/10ps
`include "bte_map.vh"
module bte_engine (
  input wire mclk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [15:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  output wire [3:0] awid,
  output wire [31:0] awaddr,
  output wire [7:0] awlen,
  output wire [2:0] awsize,
  output wire [1:0] awburst,
  output wire awlock,
  output wire [3:0] awcache,
  output wire [2:0] awprot,
  output wire [3:0] awqos,
  output wire awuser,
  output wire awvalid,
  input wire awready,
  output wire [127:0] wdata,
  output wire [15:0] wstrb,
  output wire wlast,
  output wire wvalid,
  input wire wready,
  input wire [3:0] bid,
  input wire [1:0] bresp,
  input wire bvalid,
  output wire bready,
  output wire [3:0] arid,
  output wire [31:0] araddr,
  output wire [7:0] arlen,
  output wire [2:0] arsize,
  output wire [1:0] arburst,
  output wire arlock,
  output wire [3:0] arcache,
  output wire [2:0] arprot,
  output wire [3:0] arqos,
  output wire aruser,
  output wire arvalid,
  input wire arready,
  input wire [3:0] rid,
  input wire [127:0] rdata,
  input wire rlast,
  input wire rvalid,
  output wire rready
);
  localparam SEQ_IDLE = 1'b0;
  localparam SEQ_RUN = 1'b1;
  reg [31:0] parameter_ram [0:511];
  reg [31:0] command_ram [0:2047];
  reg [31:0] upperRam [0:511];
  reg [63:0] dataRam [0:1023];
  reg [3:0] ctrl;
  reg [31:0] sBase;
  reg [31:0] sHigh;
  reg [7:0] sLen;
  reg doneFlag;
  reg seqState;
  reg runQ;
  reg [8:0] cmdPtr;
  reg [31:0] stAddr;
  reg stRead;
  reg [31:0] rdMux;
  reg [3:0] rSelOh;
  reg [3:0] wSelOh;
  reg rMatch;
  reg wMatch;
  reg [12:0] rWrIdx;
  integer k;
  wire [7:0] rsCnt;
  wire [15:0] rsId;
  wire [7:0] wsCnt;
  wire [15:0] wsId;
  wire [51:0] rgIdx;
  wire [3:0] rgBusy;
  wire [3:0] rgLast;
  wire [3:0] rHitOh;
  wire [3:0] rIdHit;

  // ==========================================================
  // APB decode of the five regions
  wire inReg = (paddr & `BTE_REG_MASK) == `BTE_REG_BASE;
  wire inPrm = (paddr & `BTE_PRM_MASK) == `BTE_PRM_BASE;
  wire inCmd = (paddr & `BTE_CMD_MASK) == `BTE_CMD_BASE;
  wire inUpa = (paddr & `BTE_UPA_MASK) == `BTE_UPA_BASE;
  wire inDat = (paddr & `BTE_DAT_MASK) == `BTE_DAT_BASE;
  wire mapped = inReg | inPrm | inCmd | inUpa | inDat;
  wire apbWr = psel && penable && pwrite && mapped;
  wire apbDatWr = apbWr && inDat;
  wire run = ctrl[`BTE_CTRL_RUN];
  wire staticMode = ctrl[`BTE_CTRL_STATIC];
  wire basicMode = ctrl[`BTE_CTRL_BASIC] | staticMode;
  wire busy = seqState | (|rsCnt) | (|wsCnt);
  // Read data is captured in the setup cycle, so no wait states are needed
  assign pready = 1'b1;

  // Read mux for every region; unlisted register offsets read zero
  always @* begin
    rdMux = 32'h0000_0000;
    if (inReg) begin
      case (paddr[11:0])
        `BTE_OFS_CTRL: rdMux = {28'h000_0000, ctrl};
        `BTE_OFS_STAT: rdMux = {8'h00, wsCnt, rsCnt, 6'h00, doneFlag, busy};
        `BTE_OFS_SBASE: rdMux = sBase;
        `BTE_OFS_SHIGH: rdMux = sHigh;
        `BTE_OFS_SLEN: rdMux = {24'h00_0000, sLen};
        default: rdMux = 32'h0000_0000;
      endcase
    end else if (inPrm) begin
      rdMux = parameter_ram[paddr[10:2]];
    end else if (inCmd) begin
      rdMux = command_ram[paddr[12:2]];
    end else if (inUpa) begin
      rdMux = upperRam[paddr[10:2]];
    end else if (inDat) begin
      rdMux = paddr[2] ? dataRam[paddr[12:3]][63:32] : dataRam[paddr[12:3]][31:0];
    end
  end

  // Setup-cycle capture; unmapped addresses answer with an error
  always @(posedge mclk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rdMux;
      pslverr <= !mapped;
    end
  end

  // Control registers
  always @(posedge mclk) begin
    if (srst) begin
      ctrl <= `BTE_CTRL_RST;
      sBase <= `BTE_ADDR_RST;
      sHigh <= `BTE_ADDR_RST;
      sLen <= `BTE_SLEN_RST;
    end else if (apbWr && inReg) begin
      case (paddr[11:0])
        `BTE_OFS_CTRL: ctrl <= pwdata[3:0];
        `BTE_OFS_SBASE: sBase <= pwdata;
        `BTE_OFS_SHIGH: sHigh <= pwdata;
        `BTE_OFS_SLEN: sLen <= pwdata[7:0];
        default: sLen <= sLen;
      endcase
    end
  end

  // Word RAMs; APB beats are single words, so bursts never interleave
  always @(posedge mclk) begin
    if (apbWr && inPrm) begin
      parameter_ram[paddr[10:2]] <= pwdata;
    end
    if (apbWr && inCmd) begin
      command_ram[paddr[12:2]] <= pwdata;
    end
    if (apbWr && inUpa) begin
      upperRam[paddr[10:2]] <= pwdata;
    end
  end

  // ==========================================================
  // Command source: command RAM list, or a synthesised static command
  wire [31:0] cw0 = command_ram[{cmdPtr, 2'b00}];
  wire [31:0] cw1 = command_ram[{cmdPtr, 2'b01}];
  wire [31:0] cw2 = command_ram[{cmdPtr, 2'b10}];
  wire cmdValid = staticMode | cw1[`BTE_C_VALID];
  wire cmdRead = staticMode ? stRead : cw1[`BTE_C_RNW];
  wire [3:0] cmdId = staticMode ? 4'h0 : cw1[`BTE_C_ID];
  wire [31:0] cmdAddr = staticMode ? stAddr : cw0;
  wire [7:0] cmdLen = staticMode ? sLen : cw1[`BTE_C_LEN];
  wire [12:0] cmdIdx = staticMode ? 13'h0000 : cw1[`BTE_C_IDX];
  // Reduced mode forces full-width INCR with fixed attributes
  wire [2:0] cmdSize = basicMode ? `BTE_SIZE_FULL : cw2[`BTE_A_SIZE];
  wire [13:0] cmdAttr = basicMode ?
    {`BTE_BURST_INCR, `BTE_LOCK_DEF, `BTE_CACHE_DEF, `BTE_PROT_DEF, `BTE_QOS_DEF} :
    {cw2[`BTE_A_BURST], cw2[`BTE_A_LOCK], cw2[`BTE_A_CACHE], cw2[`BTE_A_PROT],
     cw2[`BTE_A_QOS]};
  wire [60:0] cmdBus = {cmdId, cmdAddr, cmdLen, cmdSize, cmdAttr};
  wire [23:0] cmdIdxBus = {cmdIdx, cmdLen, cmdSize};
  wire awqInReady;
  wire arqInReady;
  wire wixInReady;
  wire live = (seqState == SEQ_RUN) && run && cmdValid;
  wire rdFire = live && cmdRead && arqInReady && (|rSelOh);
  wire wrFire = live && !cmdRead && awqInReady && wixInReady && (|wSelOh);
  wire [31:0] sweepStep = ({24'h00_0000, sLen} + 32'h0000_0001) << `BTE_SIZE_FULL;
  wire [31:0] sweepNext = stAddr + sweepStep;

  // Sequencer; enabling run restarts the list from entry zero
  always @(posedge mclk) begin
    if (srst) begin
      seqState <= SEQ_IDLE;
      runQ <= 1'b0;
      cmdPtr <= 9'h000;
      stAddr <= `BTE_ADDR_RST;
      stRead <= 1'b0;
      doneFlag <= 1'b0;
    end else begin
      runQ <= run;
      // Hardware set wins over a write-one clear in the same cycle
      doneFlag <= (doneFlag & ~(apbWr && inReg && paddr[11:0] == `BTE_OFS_STAT &&
        pwdata[`BTE_STAT_DONE])) | (live == 1'b0 && seqState == SEQ_RUN && run);
      case (seqState)
        SEQ_IDLE: begin
          if (run && !runQ) begin
            seqState <= SEQ_RUN;
            cmdPtr <= 9'h000;
            stAddr <= sBase;
            stRead <= 1'b0;
          end
        end
        SEQ_RUN: begin
          if (!run || !cmdValid) begin
            seqState <= SEQ_IDLE;
          end else if (rdFire || wrFire) begin
            cmdPtr <= cmdPtr + 9'h001;
            stRead <= !stRead;
            if (staticMode && rdFire && ctrl[`BTE_CTRL_SWEEP]) begin
              stAddr <= (sweepNext > sHigh) ? sBase : sweepNext;
            end
          end
        end
        default: seqState <= SEQ_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Two-entry address queues and the write index queue
  wire [60:0] awBus;
  wire [60:0] arBus;
  wire [23:0] wixBus;
  wire wixValid;
  wire wgBusy;
  wire wgLast;
  wire [12:0] wgIdx;
  wire wdqInReady;
  wire [64:0] wdqBus;
  bte_fifo #(.W(61), .AW(`BTE_FIFO_AW)) awQueue (
    .mclk(mclk), .srst(srst), .inValid(wrFire), .inReady(awqInReady),
    .inData(cmdBus), .outValid(awvalid), .outReady(awready), .outData(awBus));
  bte_fifo #(.W(61), .AW(`BTE_FIFO_AW)) arQueue (
    .mclk(mclk), .srst(srst), .inValid(rdFire), .inReady(arqInReady),
    .inData(cmdBus), .outValid(arvalid), .outReady(arready), .outData(arBus));
  bte_fifo #(.W(24), .AW(`BTE_FIFO_AW)) wixQueue (
    .mclk(mclk), .srst(srst), .inValid(wrFire), .inReady(wixInReady),
    .inData(cmdIdxBus), .outValid(wixValid), .outReady(!wgBusy), .outData(wixBus));
  assign {awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot, awqos} = awBus;
  assign {arid, araddr, arlen, arsize, arburst, arlock, arcache, arprot, arqos} = arBus;
  assign awuser = 1'b0;
  assign aruser = 1'b0;

  // Write data: index per beat, RAM word into the queue, copies across the bus
  bte_index_gen writeGen (
    .mclk(mclk), .srst(srst), .load(wixValid), .startIdx(wixBus[23:11]),
    .beats(wixBus[10:3]), .size(wixBus[2:0]), .step(wdqInReady), .idx(wgIdx),
    .busy(wgBusy), .last(wgLast), .done());
  bte_fifo #(.W(65), .AW(`BTE_FIFO_AW)) writeDataQueue (
    .mclk(mclk), .srst(srst), .inValid(wgBusy), .inReady(wdqInReady),
    .inData({wgLast, dataRam[wgIdx[12:3]]}), .outValid(wvalid), .outReady(wready),
    .outData(wdqBus));
  assign wdata = {`BTE_REPL{wdqBus[63:0]}};
  assign wlast = wdqBus[64];
  // Holes in the strobe are not produced; every byte lane is written
  assign wstrb = 16'hFFFF;
  assign bready = 1'b1;

  // ==========================================================
  // Read return queue; only the low 64 bits of each beat are kept
  wire rqValid;
  wire [68:0] rqBus;
  wire [3:0] rqId = rqBus[68:65];
  wire rqReady = !apbDatWr && ((|rHitOh) || !(|rIdHit));
  wire rqPop = rqValid && rqReady;
  bte_fifo #(.W(69), .AW(`BTE_FIFO_AW)) readReturnQueue (
    .mclk(mclk), .srst(srst), .inValid(rvalid), .inReady(rready),
    .inData({rid, rlast, rdata[63:0]}), .outValid(rqValid), .outReady(rqReady),
    .outData(rqBus));

  // Tracker slot choice: same ID reuses its slot, else first free slot
  always @* begin
    rSelOh = 4'h0;
    wSelOh = 4'h0;
    rMatch = 1'b0;
    wMatch = 1'b0;
    rWrIdx = 13'h0000;
    for (k = 0; k < `BTE_SLOTS; k = k + 1) begin
      if (rsCnt[k*2 +: 2] != 2'd0 && rsId[k*4 +: 4] == cmdId) begin
        rMatch = 1'b1;
        rSelOh[k] = (rsCnt[k*2 +: 2] != 2'd2);
      end
      if (wsCnt[k*2 +: 2] != 2'd0 && wsId[k*4 +: 4] == cmdId) begin
        wMatch = 1'b1;
        wSelOh[k] = (wsCnt[k*2 +: 2] != 2'd3);
      end
      if (rHitOh[k]) begin
        rWrIdx = rgIdx[k*13 +: 13];
      end
    end
    for (k = 0; k < `BTE_SLOTS; k = k + 1) begin
      if (!rMatch && rSelOh == 4'h0 && rsCnt[k*2 +: 2] == 2'd0) begin
        rSelOh[k] = 1'b1;
      end
      if (!wMatch && wSelOh == 4'h0 && wsCnt[k*2 +: 2] == 2'd0) begin
        wSelOh[k] = 1'b1;
      end
    end
  end

  // Data RAM writes: returned read beats, or APB when no beat is popped
  always @(posedge mclk) begin
    if (rqPop && (|rHitOh)) begin
      dataRam[rWrIdx[12:3]] <= rqBus[63:0];
    end else if (apbDatWr && !paddr[2]) begin
      dataRam[paddr[12:3]][31:0] <= pwdata;
    end else if (apbDatWr) begin
      dataRam[paddr[12:3]][63:32] <= pwdata;
    end
  end

  // ==========================================================
  // Four tracker slots, each with a read queue, read generator and write count
  genvar g;
  generate
    for (g = 0; g < `BTE_SLOTS; g = g + 1) begin : slot
      reg [1:0] rCnt;
      reg [3:0] rId;
      reg [23:0] q0;
      reg [23:0] q1;
      reg [1:0] wCnt;
      reg [3:0] wId;
      wire rPush = rdFire && rSelOh[g];
      wire rPop = rqPop && rHitOh[g] && rgLast[g];
      wire wPush = wrFire && wSelOh[g];
      wire wPop = bvalid && (wCnt != 2'd0) && (bid == wId);
      assign rIdHit[g] = rqValid && (rCnt != 2'd0) && (rId == rqId);
      assign rHitOh[g] = rIdHit[g] && rgBusy[g];
      assign rsCnt[g*2 +: 2] = rCnt;
      assign rsId[g*4 +: 4] = rId;
      assign wsCnt[g*2 +: 2] = wCnt;
      assign wsId[g*4 +: 4] = wId;
      bte_index_gen readGen (
        .mclk(mclk), .srst(srst), .load(rCnt != 2'd0), .startIdx(q0[23:11]),
        .beats(q0[10:3]), .size(q0[2:0]), .step(rqPop && rHitOh[g]),
        .idx(rgIdx[g*13 +: 13]), .busy(rgBusy[g]), .last(rgLast[g]), .done());
      // Queue head stays loaded until its last beat has been written
      always @(posedge mclk) begin
        if (srst) begin
          rCnt <= 2'd0;
          rId <= 4'h0;
          q0 <= 24'h00_0000;
          q1 <= 24'h00_0000;
          wCnt <= 2'd0;
          wId <= 4'h0;
        end else begin
          if (rPop) begin
            q0 <= q1;
          end
          if (rPush && (rCnt == 2'd0 || (rCnt == 2'd1 && rPop))) begin
            q0 <= cmdIdxBus;
          end else if (rPush) begin
            q1 <= cmdIdxBus;
          end
          if (rPush && rCnt == 2'd0) begin
            rId <= cmdId;
          end
          rCnt <= rCnt + {1'b0, rPush} - {1'b0, rPop};
          if (wPush && wCnt == 2'd0) begin
            wId <= cmdId;
          end
          wCnt <= wCnt + {1'b0, wPush} - {1'b0, wPop};
        end
      end
    end
  endgenerate
endmodule

// ===== bte_engine_props.sv
// Checker for the engine ports: channel holding, write fill, APB decode.
// Assumes it is bound onto every bte_engine instance.
`timescale 1ns/10ps
// ================================
// Port properties
module bte_engine_props (
  input wire mclk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire [15:0] paddr,
  input wire pslverr,
  input wire [31:0] awaddr,
  input wire awuser,
  input wire awvalid,
  input wire awready,
  input wire [127:0] wdata,
  input wire [15:0] wstrb,
  input wire wlast,
  input wire wvalid,
  input wire wready,
  input wire [31:0] araddr,
  input wire aruser,
  input wire arvalid,
  input wire arready
);
  // Upper half of the upper address area is not mapped
  wire mapped = paddr < 16'h1800 || (paddr >= 16'h8000 && paddr < 16'hA800) ||
    (paddr >= 16'hC000 && paddr < 16'hE000);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  map_err_a: assert property (psel && !penable |=> pslverr == !mapped)
    else $error("pslverr wrong for address");
  rep_data_a: assert property (wvalid |-> wdata[127:64] == wdata[63:0])
    else $error("write halves differ");
  full_strb_a: assert property (wvalid |-> wstrb == 16'hFFFF)
    else $error("partial write strobe");
  aw_hold_a: assert property (awvalid && !awready |=> awvalid && $stable(awaddr))
    else $error("write address dropped");
  ar_hold_a: assert property (arvalid && !arready |=> arvalid && $stable(araddr))
    else $error("read address dropped");
  w_hold_a: assert property (wvalid && !wready |=> wvalid && $stable({wlast, wdata}))
    else $error("write beat dropped");
  user_zero_a: assert property (awvalid || arvalid |-> !awuser && !aruser)
    else $error("user bit set");
  // Reset itself is the trigger here, so no disable
  rst_quiet_a: assert property (disable iff (1'b0) srst |=> !awvalid && !arvalid && !wvalid)
    else $error("traffic after reset");
endmodule
bind bte_engine bte_engine_props i_bte_engine_props (.*);

// ===== bte_engine_tb.sv
// Self-checking bench: APB map, data RAM, a four-command run, a static sweep.
// Assumes the engine, the memory model and the checker are compiled.
`timescale 1ns/10ps
// ================================
// Bench top
module bte_engine_tb;
  reg mclk = 1'b0;
  reg srst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [15:0] paddr = 16'h0000;
  reg [31:0] pwdata = 32'h0;
  wire [31:0] prdata, awaddr, araddr;
  wire pready, pslverr, awlock, awuser, awvalid, awready, wlast, wvalid, wready;
  wire bvalid, bready, arlock, aruser, arvalid, arready, rlast, rvalid, rready;
  wire [3:0] awid, awcache, awqos, bid, arid, arcache, arqos, rid;
  wire [7:0] awlen, arlen;
  wire [2:0] awsize, awprot, arsize, arprot;
  wire [1:0] awburst, bresp, arburst;
  wire [127:0] wdata, rdata;
  wire [15:0] wstrb;
  reg [32:0] expQ [$];
  reg [127:0] wExpQ [$];
  reg [63:0] w0, w2;
  // Fixed static attributes: id 0, one beat, full size, INCR, cache 3
  localparam [28:0] FIX_ATTR = {4'h0, 8'h00, 3'h4, 2'h1, 1'b0, 4'h3, 3'h0, 4'h0};
  wire [60:0] awGot = {awid, awlen, awsize, awburst, awlock, awcache, awprot, awqos, awaddr};
  wire [60:0] arGot = {arid, arlen, arsize, arburst, arlock, arcache, arprot, arqos, araddr};
  reg staticOn = 1'b0;
  reg [31:0] awNext = 32'h100;
  reg [31:0] arNext = 32'h100;
  integer errCount = 0;
  integer testsRun = 0;
  integer cyc = 0;
  integer k;
  always #5 mclk = ~mclk;
  bte_engine i_bte_engine (.*);
  bte_axi_mem i_bte_axi_mem (.*);
  task check(input reg [127:0] e, input reg [127:0] g);
    begin
      testsRun = testsRun + 1;
      if (g !== e) begin
        errCount = errCount + 1;
        $display("unexpected at %0t: exp %h got %h", $time, e, g);
      end
    end
  endtask
  task apb(input reg wr, input reg [15:0] a, input reg [31:0] d, input reg [32:0] e);
    begin
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) expQ.push_back(e);
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wrrd(input reg [15:0] a, input reg [31:0] v);
    begin
      apb(1'b1, a, v, 33'h0);
      apb(1'b0, a, 32'h0, {1'b0, v});
    end
  endtask
  task waitr(input integer n);
    begin
      repeat (n) begin
        @(posedge mclk);
        while ((rvalid & rready) !== 1'b1) @(posedge mclk);
      end
    end
  endtask
  task summarize;
    begin
      $display("mismatches %0d of %0d checks", errCount, testsRun);
      if (errCount == 0 && testsRun > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Handshakes are taken at the rising edge, from the values that stood before it
  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({95'h0, expQ.pop_front()}, {95'h0, pslverr, prdata});
    if (wvalid === 1'b1 && wready)
      check(wExpQ.pop_front(), wdata);
    // Static sweep walks base, base+16, high, then wraps to base
    if (awvalid === 1'b1 && awready && staticOn) begin
      wExpQ.push_back({w0, w0});
      check({67'h0, FIX_ATTR, awNext}, {67'h0, awGot});
      awNext <= (awNext == 32'h120) ? 32'h100 : awNext + 32'h10;
    end
    if (arvalid === 1'b1 && arready && staticOn) begin
      check({67'h0, FIX_ATTR, arNext}, {67'h0, arGot});
      arNext <= (arNext == 32'h120) ? 32'h100 : arNext + 32'h10;
    end
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errCount = errCount + 1;
      summarize;
    end
  end
  initial begin
    w0 = {$urandom(51033), $urandom};
    w2 = {$urandom, $urandom};
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, 16'h0000, 32'h0, 33'h0);
    apb(1'b0, 16'h0010, 32'h0, 33'h0F);
    for (k = 0; k < 4; k = k + 1)
      apb(1'b0, 16'h1800 + 16'(k * 16'h4800), 32'h0, 33'h1_0000_0000);
    wrrd(16'h17FC, w2[31:0]);
    wrrd(16'hA7FC, w2[63:32]);
    wrrd(16'h0008, w0[63:32]);
    wrrd(16'hC000, w0[31:0]);
    wrrd(16'hC004, w0[63:32]);
    wrrd(16'hC010, w2[31:0]);
    wrrd(16'hC014, w2[63:32]);
    // Two writes then two reads of the same lines, distinct IDs
    for (k = 0; k < 4; k = k + 1) begin
      apb(1'b1, 16'h8000 + 16'(k * 16), 32'h100 + 32'(k[0] * 16), 33'h0);
      apb(1'b1, 16'h8004 + 16'(k * 16),
        {1'b1, k[1], 2'h0, 4'h1 + k[3:0], 11'h0, 7'h0, k[1], k[0], 4'h0}, 33'h0);
      apb(1'b1, 16'h8008 + 16'(k * 16), 32'h0000_0314, 33'h0);
    end
    apb(1'b1, 16'h8044, 32'h0, 33'h0);
    wExpQ.push_back({w0, w0});
    wExpQ.push_back({w2, w2});
    check(128'h0, {125'h0, awvalid, arvalid, wvalid});
    apb(1'b1, 16'h0000, 32'h0000_0009, 33'h0);
    waitr(2);
    apb(1'b0, 16'hC020, 32'h0, {1'b0, w0[31:0]});
    apb(1'b0, 16'hC024, 32'h0, {1'b0, w0[63:32]});
    apb(1'b0, 16'hC030, 32'h0, {1'b0, w2[31:0]});
    apb(1'b0, 16'hC034, 32'h0, {1'b0, w2[63:32]});
    // Static sweep: run must fall before it can rise again
    apb(1'b1, 16'h0000, 32'h0, 33'h0);
    apb(1'b1, 16'h0010, 32'h0, 33'h0);
    apb(1'b1, 16'h0008, 32'h100, 33'h0);
    apb(1'b1, 16'h000C, 32'h120, 33'h0);
    staticOn = 1'b1;
    apb(1'b1, 16'h0000, 32'h7, 33'h0);
    waitr(4);
    apb(1'b1, 16'h0000, 32'h0, 33'h0);
    repeat (100) @(posedge mclk);
    check(128'h0, 128'(wExpQ.size()));
    apb(1'b0, 16'h0004, 32'h0, 33'h2);
    summarize;
  end
endmodule

// ===== bte_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module bte_fifo #(
  parameter W = 8,
  parameter AW = 1
) (
  input wire mclk,
  input wire srst,
  input wire inValid,
  output wire inReady,
  input wire [W-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [W-1:0] outData
);
  localparam [AW:0] FULL = {1'b1, {AW{1'b0}}};
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;
  // ==========================================================
  // Flags straight from the fill count, so full and empty are exact
  assign inReady = (count != FULL);
  assign outValid = (count != {(AW+1){1'b0}});
  assign outData = mem[rdPtr];
  // Storage needs no reset; the count decides what is valid
  always @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end
  // Pointers and fill count
  always @(posedge mclk) begin
    if (srst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= rdPtr + 1'b1;
      end
      count <= count + {{AW{1'b0}}, doPush} - {{AW{1'b0}}, doPop};
    end
  end
endmodule

// ===== bte_index_gen.v
// Per-burst data RAM index generator: byte index per beat and beat count.
// Assumes the caller steps it once per accepted beat.
`timescale 1ns/10ps
module bte_index_gen (
  input wire mclk,
  input wire srst,
  input wire load,
  input wire [12:0] startIdx,
  input wire [7:0] beats,
  input wire [2:0] size,
  input wire step,
  output reg [12:0] idx,
  output reg busy,
  output wire last,
  output reg done
);
  reg [7:0] count;
  reg [7:0] len;
  reg [2:0] sz;
  wire [12:0] stepBytes = 13'h0001 << sz;
  // ==========================================================
  // Last beat when the count reaches the burst length
  assign last = busy && (count == len);
  // Later beats land on size-aligned indices, as the bus addresses do
  always @(posedge mclk) begin
    if (srst) begin
      idx <= 13'h0000;
      busy <= 1'b0;
      done <= 1'b0;
      count <= 8'h00;
      len <= 8'h00;
      sz <= 3'h0;
    end else begin
      done <= 1'b0;
      if (load && !busy) begin
        idx <= startIdx;
        len <= beats;
        sz <= size;
        count <= 8'h00;
        busy <= 1'b1;
      end else if (step && busy) begin
        idx <= (idx & ~(stepBytes - 13'h0001)) + stepBytes;
        count <= count + 8'h01;
        if (count == len) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== bte_map.vh
// Constants for the bus traffic engine: region map, register offsets,
// control fields, command entry layout and the fixed bus attributes.
// Assumes inclusion by every engine source file; definitions only.
`ifndef BTE_MAP_VH
`define BTE_MAP_VH
// ==========================================================
// Region bases and decode masks on the 16-bit APB address
`define BTE_REG_BASE 16'h0000
`define BTE_REG_MASK 16'hF000
`define BTE_PRM_BASE 16'h1000
`define BTE_PRM_MASK 16'hF800
`define BTE_CMD_BASE 16'h8000
`define BTE_CMD_MASK 16'hE000
`define BTE_UPA_BASE 16'hA000
`define BTE_UPA_MASK 16'hF800
`define BTE_DAT_BASE 16'hC000
`define BTE_DAT_MASK 16'hE000
// ==========================================================
// Register offsets inside the register region
`define BTE_OFS_CTRL 12'h000
`define BTE_OFS_STAT 12'h004
`define BTE_OFS_SBASE 12'h008
`define BTE_OFS_SHIGH 12'h00C
`define BTE_OFS_SLEN 12'h010
// Control bits and reset values
`define BTE_CTRL_RUN 0
`define BTE_CTRL_STATIC 1
`define BTE_CTRL_SWEEP 2
`define BTE_CTRL_BASIC 3
`define BTE_CTRL_RST 4'h0
`define BTE_SLEN_RST 8'h0F
`define BTE_ADDR_RST 32'h0000_0000
// Status bits
`define BTE_STAT_BUSY 0
`define BTE_STAT_DONE 1
// ==========================================================
// Command entry: four words, word 0 address, word 1 control, word 2 attributes
`define BTE_C_VALID 31
`define BTE_C_RNW 30
`define BTE_C_ID 27:24
`define BTE_C_LEN 23:16
`define BTE_C_IDX 12:0
`define BTE_A_SIZE 2:0
`define BTE_A_BURST 5:4
`define BTE_A_LOCK 6
`define BTE_A_CACHE 11:8
`define BTE_A_PROT 14:12
`define BTE_A_QOS 19:16
// ==========================================================
// Fixed attributes for reduced and static traffic, master data width
`define BTE_BURST_INCR 2'h1
`define BTE_LOCK_DEF 1'b0
`define BTE_CACHE_DEF 4'h3
`define BTE_PROT_DEF 3'h0
`define BTE_QOS_DEF 4'h0
`define BTE_SIZE_FULL 3'h4
`define BTE_MDW 128
`define BTE_REPL 2
`define BTE_SLOTS 4
`define BTE_FIFO_AW 1
`endif
